// ==== ces_alu.sv ====
`timescale 1ns/100ps
`default_nettype none
module ces_alu
(
   input  wire  ces_pkg::ces_alu_e op,
   input  wire  logic [7:0]        acc,
   input  wire  logic [7:0]        mem,
   input  wire  logic              cin,
   output logic [7:0]              res,
   output logic                    cout
);
   import ces_pkg::*;

   logic [8:0] sum;

   // ==========================================================
   // Subtraction is done as a + ~b + carry, so a set carry means no borrow.
   always_comb
   begin
      sum  = 9'h000;
      res  = 8'h00;
      cout = 1'b0;
      unique case (op)
         ALU_ADD:
         begin
            sum = {1'b0, mem} + {1'b0, acc} + {8'h00, cin};
         end
         ALU_MMD:
         begin
            sum = {1'b0, mem} + {1'b0, ~acc} + {8'h00, cin};
         end
         ALU_DMM:
         begin
            sum = {1'b0, acc} + {1'b0, ~mem} + {8'h00, cin};
         end
         ALU_SHR:
         begin
            sum = {acc[0], cin, acc[7:1]};
         end
      endcase
      res  = sum[7:0];
      cout = sum[8];
   end
endmodule : ces_alu
`default_nettype wire

// ==== ces_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ces_defs.svh"
// How it works
// - Carry changes only on arithmetic and shift.
// - Add sets carry on carry out.
// - Subtract sets carry when no borrow.
// - Wait opcode repeats execute reading R0.
// - Long branch, skip, no-op take three cycles.
// - Long branch: opcode plus two address bytes.
// - Taken long branch loads both counter bytes.
// - Short branch tests flags, carry, latch, accumulator.
// - Taken short branch replaces low counter byte.
// - Short skip: two cycles, skip one byte.
// - Long skip adds two when condition holds.
// - Reset clears state, drives 00, init clears R0.
// - Fetch reads at counter, latches opcode, increments.
// - Increment/decrement float bus, strobes high.
// - Stores drive data, pulse write strobe low.
// - Output reads pointer memory, selects device, advances.
// - Input stores device byte, loads accumulator.
// - Return/disable load selectors, set or clear enable.
// - Add with carry into accumulator and carry.
// - Subtract with borrow into accumulator and carry.
// - Right rotate through carry, bus floats.
// - Load via pointer then advance pointer.
module ces_core
(
   input  wire  logic        clk_sys,
   input  wire  logic        srst,
   input  wire  logic        clk_en,
   input  wire  logic [7:0]  data_in,
   input  wire  logic [3:0]  external_flag_inputs,
   input  wire  logic        int_req,
   input  wire  logic        dma_req,
   output logic [15:0]       mem_addr,
   output logic [7:0]        data_out,
   output logic              data_oe,
   output logic              memory_read_strobe_n,
   output logic              memory_write_strobe_n,
   output logic [2:0]        io_select_code,
   output logic              io_ack,
   output logic              carry_flag,
   output logic              interrupt_enable,
   output logic              q_flag
);
   import ces_pkg::*;

   ces_state_e  state;
   logic [1:0]  phase;
   logic [15:0] regs [0:15];
   logic [3:0]  op_hi;
   logic [3:0]  op_lo;
   logic [3:0]  sel_x;
   logic [3:0]  sel_p;
   logic [7:0]  acc;
   logic [7:0]  tsave;
   logic [7:0]  bhold;
   logic [7:0]  din_s1;
   logic [7:0]  din;
   logic [3:0]  ef_s1;
   logic [3:0]  ef;
   logic [1:0]  req_s1;
   logic [1:0]  req;
   logic        last_ph;
   logic        cyc_end;
   logic        is_ctl;
   logic        is_lbr;
   logic        is_idle;
   logic        int_go;
   logic        io_go;
   logic [3:0]  a_idx;
   logic        c_rd;
   logic        c_wr;
   logic        c_drv;
   logic [7:0]  c_dout;
   logic [2:0]  c_io;
   logic        wr_en;
   logic [3:0]  wr_idx;
   logic [15:0] wr_val;
   ces_state_e  next_state;
   ces_alu_e    alu_op;
   logic [7:0]  alu_res;
   logic        alu_cout;
   logic        alu_use;

   // ==========================================================
   // Condition helpers.
   function automatic logic flag_sel(input logic [1:0] s, input logic qv,
                                     input logic [7:0] dv, input logic cv);
      flag_sel = (s == 2'h0) ? 1'b1 : (s == 2'h1) ? qv : (s == 2'h2) ? (dv == 8'h00) : cv;
   endfunction : flag_sel

   // Long group: 0-3 and 8-B branch, 4-7 and C-F skip or no-op.
   function automatic logic long_cond(input logic [3:0] n, input logic qv,
                                      input logic [7:0] dv, input logic cv,
                                      input logic iev);
      logic b;
      b = flag_sel(n[1:0], qv, dv, cv);
      if (!n[2])
         long_cond = n[3] ? ~b : b;
      else if (n[3])
         long_cond = (n[1:0] == 2'h0) ? iev : b;
      else
         long_cond = (n[1:0] == 2'h0) ? 1'b0 : ~b;
   endfunction : long_cond

   // ==========================================================
   // Pins from outside the clock domain pass two flip-flops.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         din_s1 <= 8'h00;
         din    <= 8'h00;
         ef_s1  <= 4'h0;
         ef     <= 4'h0;
         req_s1 <= 2'h0;
         req    <= 2'h0;
      end
      else if (clk_en)
      begin
         din_s1 <= data_in;
         din    <= din_s1;
         ef_s1  <= external_flag_inputs;
         ef     <= ef_s1;
         req_s1 <= {dma_req, int_req};
         req    <= req_s1;
      end
   end

   assign last_ph = (phase == `CES_PH_LAST);
   assign cyc_end = clk_en && last_ph;
   assign is_ctl  = (op_hi == `CES_G_CTL);
   assign is_lbr  = (op_hi == `CES_G_LBR);
   assign is_idle = (op_hi == `CES_G_LDN) && (op_lo == `CES_R0);
   assign int_go  = req[0] && interrupt_enable;
   assign io_go   = int_go || req[1];

   // ==========================================================
   // Bus command for the current machine state.
   always_comb
   begin
      a_idx  = sel_p;
      c_rd   = 1'b0;
      c_wr   = 1'b0;
      c_drv  = 1'b0;
      c_dout = `CES_RST_BUS;
      c_io   = 3'h0;
      unique case (state)
         ST_RESET, ST_INIT:
         begin
            c_drv = 1'b1;
         end
         ST_FETCH:
         begin
            c_rd = 1'b1;
         end
         ST_EXEC, ST_EXEC2:
         begin
            unique case (op_hi)
               `CES_G_LDN:
               begin
                  a_idx = op_lo;
                  c_rd  = 1'b1;
               end
               `CES_G_INC, `CES_G_DEC:
               begin
                  a_idx = op_lo;
               end
               `CES_G_SBR, `CES_G_LBR:
               begin
                  c_rd = 1'b1;
               end
               `CES_G_LDA:
               begin
                  a_idx = op_lo;
                  c_rd  = 1'b1;
               end
               `CES_G_STR:
               begin
                  a_idx = op_lo;
                  c_wr  = 1'b1;
                  c_drv = 1'b1;
                  c_dout = acc;
               end
               `CES_G_IO:
               begin
                  a_idx = sel_x;
                  c_io  = op_lo[2:0];
                  c_rd  = !op_lo[3];
                  c_wr  = (op_lo >= `CES_N_INP_MIN);
               end
               `CES_G_CTL:
               begin
                  a_idx = sel_x;
                  c_rd  = (op_lo <= `CES_N_SMB) && (op_lo != `CES_N_STORE_POINTER_DECREMENT_OP)
                          && (op_lo != `CES_N_ROTATE_RIGHT_CARRY_OP);
                  c_wr  = (op_lo == `CES_N_STORE_POINTER_DECREMENT_OP) || (op_lo == `CES_N_SAV);
                  c_drv = c_wr;
                  c_dout = (op_lo == `CES_N_SAV) ? tsave : acc;
               end
               default:
               begin
                  a_idx = sel_p;
               end
            endcase
         end
      endcase
   end

   // ==========================================================
   // Bus pins are loaded at the start of each machine cycle so they hold
   // steady while memory answers; the write strobe is a pulse inside it.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         phase                 <= 2'h0;
         mem_addr              <= 16'h0000;
         data_out              <= `CES_RST_BUS;
         data_oe               <= 1'b1;
         memory_read_strobe_n  <= 1'b1;
         memory_write_strobe_n <= 1'b1;
         io_select_code        <= 3'h0;
      end
      else if (clk_en)
      begin
         phase <= phase + 2'h1;
         if (phase == `CES_PH_DRIVE)
         begin
            mem_addr             <= (state == ST_RESET || state == ST_INIT) ? 16'h0000
                                    : regs[a_idx];
            data_out             <= c_dout;
            data_oe              <= c_drv;
            memory_read_strobe_n <= !c_rd;
            io_select_code       <= c_io;
         end
         if (phase == `CES_PH_WR_ON)
            memory_write_strobe_n <= !c_wr;
         else if (last_ph)
            memory_write_strobe_n <= 1'b1;
      end
   end

   // ==========================================================
   // Arithmetic unit and its operand choice.
   always_comb
   begin
      alu_use = is_ctl && ((op_lo == `CES_N_ADC) || (op_lo == `CES_N_SDB)
                || (op_lo == `CES_N_ROTATE_RIGHT_CARRY_OP) || (op_lo == `CES_N_SMB));
      unique case (op_lo[1:0])
         2'h0:    alu_op = ALU_ADD;
         2'h1:    alu_op = ALU_MMD;
         2'h2:    alu_op = ALU_SHR;
         default: alu_op = ALU_DMM;
      endcase
   end

   ces_alu u_alu
   (
      .op   (alu_op),
      .acc  (acc),
      .mem  (din),
      .cin  (carry_flag),
      .res  (alu_res),
      .cout (alu_cout)
   );

   // ==========================================================
   // Sequencing of machine states.
   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_RESET: next_state = ST_INIT;
         ST_INIT:  next_state = ST_FETCH;
         ST_FETCH: next_state = ST_EXEC;
         ST_EXEC:
         begin
            if (is_lbr)
               next_state = ST_EXEC2;
            else if (is_idle && !io_go)
               next_state = ST_EXEC;
            else
               next_state = ST_FETCH;
         end
         ST_EXEC2: next_state = ST_FETCH;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
         state <= ST_RESET;
      else if (cyc_end)
         state <= next_state;
   end

   // ==========================================================
   // Scratchpad write port: only one register changes per cycle.
   always_comb
   begin
      wr_en  = 1'b0;
      wr_idx = sel_p;
      wr_val = regs[sel_p] + 16'h0001;
      if (state == ST_INIT)
      begin
         wr_en  = 1'b1;
         wr_idx = `CES_R0;
         wr_val = `CES_R_INIT;
      end
      else if (state == ST_FETCH)
         wr_en = 1'b1;
      else if (state == ST_EXEC || state == ST_EXEC2)
      begin
         unique case (op_hi)
            `CES_G_INC, `CES_G_DEC, `CES_G_LDA:
            begin
               wr_en  = 1'b1;
               wr_idx = op_lo;
               wr_val = (op_hi == `CES_G_DEC) ? regs[op_lo] - 16'h0001
                        : regs[op_lo] + 16'h0001;
            end
            `CES_G_SBR:
            begin
               wr_en  = 1'b1;
               if (op_lo[3] ^ (op_lo[2] ? ef[op_lo[1:0]]
                               : flag_sel(op_lo[1:0], q_flag, acc, carry_flag)))
                  wr_val = {regs[sel_p][15:8], din};
            end
            `CES_G_IO:
            begin
               wr_en  = !op_lo[3];
               wr_idx = sel_x;
               wr_val = regs[sel_x] + 16'h0001;
            end
            `CES_G_CTL:
            begin
               wr_idx = sel_x;
               wr_en  = (op_lo <= `CES_N_STORE_POINTER_DECREMENT_OP);
               wr_val = (op_lo == `CES_N_STORE_POINTER_DECREMENT_OP) ? regs[sel_x] - 16'h0001
                        : regs[sel_x] + 16'h0001;
            end
            `CES_G_LBR:
            begin
               if (!op_lo[2])
               begin
                  wr_en = 1'b1;
                  if (state == ST_EXEC2 && long_cond(op_lo, q_flag, acc, carry_flag,
                                                     interrupt_enable))
                     wr_val = {bhold, din};
               end
               else
                  wr_en = long_cond(op_lo, q_flag, acc, carry_flag,
                                    interrupt_enable);
            end
            default:
            begin
               wr_en = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (cyc_end && wr_en)
         regs[wr_idx] <= wr_val;
   end

   // ==========================================================
   // Opcode, selectors, enable, latch bit and interrupt entry.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         op_hi            <= `CES_RST_NIB;
         op_lo            <= `CES_RST_NIB;
         sel_x            <= `CES_RST_NIB;
         sel_p            <= `CES_RST_NIB;
         q_flag           <= 1'b0;
         interrupt_enable <= `CES_RST_IE;
         tsave            <= 8'h00;
         io_ack           <= 1'b0;
      end
      else if (clk_en)
      begin
         io_ack <= 1'b0;
         if (last_ph && state == ST_FETCH)
         begin
            op_hi <= din[7:4];
            op_lo <= din[3:0];
         end
         if (last_ph && state == ST_EXEC && is_ctl && op_lo <= `CES_N_DIS)
         begin
            sel_x            <= din[7:4];
            sel_p            <= din[3:0];
            interrupt_enable <= !op_lo[0];
         end
         // Requests are taken only where an instruction ends.
         if (last_ph && next_state == ST_FETCH && (state == ST_EXEC || state == ST_EXEC2)
             && io_go)
         begin
            io_ack <= 1'b1;
            if (int_go)
            begin
               tsave            <= {sel_x, sel_p};
               sel_x            <= `CES_INT_X;
               sel_p            <= `CES_INT_P;
               interrupt_enable <= 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // Accumulator, carry and the high address byte hold.
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         acc        <= 8'h00;
         carry_flag <= 1'b0;
         bhold      <= 8'h00;
      end
      else if (cyc_end && state == ST_EXEC)
      begin
         if ((op_hi == `CES_G_LDN && !is_idle) || op_hi == `CES_G_LDA)
            acc <= din;
         if (op_hi == `CES_G_IO && op_lo >= `CES_N_INP_MIN)
            acc <= din;
         if (is_ctl && op_lo == `CES_N_LOAD_POINTER_ADVANCE_OP)
            acc <= din;
         if (alu_use)
         begin
            acc        <= alu_res;
            carry_flag <= alu_cout;
         end
         if (is_lbr)
            bhold <= din;
      end
   end
endmodule : ces_core
`default_nettype wire

// ==== ces_core_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// ===========================================================
// Bus and sequencing properties seen at the core's pins.
module ces_core_asserts
(
   input wire logic        clk_sys,
   input wire logic        srst,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  data_out,
   input wire logic        data_oe,
   input wire logic        memory_read_strobe_n,
   input wire logic        memory_write_strobe_n,
   input wire logic [2:0]  io_select_code,
   input wire logic        io_ack,
   input wire logic        carry_flag,
   input wire logic        interrupt_enable
);
   logic rd_n;
   logic wr_n;
   // Short aliases keep the properties readable.
   assign rd_n = memory_read_strobe_n;
   assign wr_n = memory_write_strobe_n;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   // ===========================================================
   // Properties.
   rst_bus_a: assert property (disable iff (1'b0) srst |=> data_out == 8'h00 && data_oe
      && rd_n && wr_n && interrupt_enable && io_select_code == 3'h0)
      else $error("reset state not driven");
   rst_exit_a: assert property ($fell(srst) |-> (rd_n && data_oe)[*6]
      ##[1:6] (!rd_n && mem_addr == 16'h0000)) else $error("first fetch not at zero");
   wr_len_a: assert property ($fell(wr_n) |=> !wr_n ##1 wr_n)
      else $error("write strobe not two clocks");
   wr_rd_a: assert property (!wr_n |-> rd_n) else $error("both strobes low");
   wr_src_a: assert property (!wr_n |-> data_oe == (io_select_code == 3'h0))
      else $error("wrong bus source on write");
   rd_float_a: assert property (!rd_n |-> !data_oe) else $error("bus driven on read");
   addr_hold_a: assert property ($changed(mem_addr) |=> $stable(mem_addr)[*3])
      else $error("address shorter than a machine cycle");
   io_dir_a: assert property (io_select_code != 3'h0 |-> !data_oe)
      else $error("bus driven in an I/O cycle");
   sel_hold_a: assert property ($changed(io_select_code) |=> $stable(io_select_code)[*3])
      else $error("select lines shorter than a cycle");
   ack_once_a: assert property (io_ack |=> !io_ack) else $error("acknowledge too long");
   carry_keep_a: assert property (!wr_n |=> $stable(carry_flag))
      else $error("carry moved during a store");
   // Main scenarios reached.
   cov_store: cover property (!wr_n && data_oe);
   cov_input: cover property (!wr_n && io_select_code != 3'h0);
   cov_ack: cover property (io_ack);
endmodule : ces_core_asserts
bind ces_core ces_core_asserts u_chk(.clk_sys(clk_sys), .srst(srst), .mem_addr(mem_addr),
   .data_out(data_out), .data_oe(data_oe), .memory_read_strobe_n(memory_read_strobe_n),
   .memory_write_strobe_n(memory_write_strobe_n), .io_select_code(io_select_code),
   .io_ack(io_ack), .carry_flag(carry_flag), .interrupt_enable(interrupt_enable));
`default_nettype wire

// ==== ces_defs.svh ====
`ifndef CES_DEFS_SVH
`define CES_DEFS_SVH
// =============================================================
// Machine cycle timing
`define CES_PH_DRIVE     2'h0
`define CES_PH_WR_ON     2'h1
`define CES_PH_LAST      2'h3
// =============================================================
// Reset values and fixed indices
`define CES_RST_NIB      4'h0
`define CES_RST_IE       1'b1
`define CES_RST_BUS      8'h00
`define CES_R0           4'h0
`define CES_R_INIT       16'h0000
`define CES_INT_P        4'h1
`define CES_INT_X        4'h2
// =============================================================
// Opcode groups (upper nibble)
`define CES_G_LDN        4'h0
`define CES_G_INC        4'h1
`define CES_G_DEC        4'h2
`define CES_G_SBR        4'h3
`define CES_G_LDA        4'h4
`define CES_G_STR        4'h5
`define CES_G_IO         4'h6
`define CES_G_CTL        4'h7
`define CES_G_LBR        4'hC
// =============================================================
// Low nibbles of the control and I/O groups
`define CES_N_RET        4'h0
`define CES_N_DIS        4'h1
`define CES_N_LOAD_POINTER_ADVANCE_OP       4'h2
`define CES_N_STORE_POINTER_DECREMENT_OP       4'h3
`define CES_N_ADC        4'h4
`define CES_N_SDB        4'h5
`define CES_N_ROTATE_RIGHT_CARRY_OP       4'h6
`define CES_N_SMB        4'h7
`define CES_N_SAV        4'h8
`define CES_N_IRX        4'h0
`define CES_N_INP_MIN    4'h9
`endif

// ==== ces_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ===========================================================
// Memory plus one I/O port on the far side of the bus.
module ces_mem_model
#(
   parameter logic [7:0] IO_BYTE = 8'hC4
)
(
   input wire logic        clk_sys,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  data_out,
   input wire logic        data_oe,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic [2:0]  sel,
   output logic [7:0]      data_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;
   logic [7:0] io_got = 8'h00;
   logic [2:0] io_sel = 3'h0;
   // An undriven bus toggles so a stale byte can never pass as data.
   always_comb
   begin
      if (!rd_n)
         data_in = mem[mem_addr];
      else if (data_oe)
         data_in = data_out;
      else if (sel != 3'h0)
         data_in = IO_BYTE;
      else
         data_in = ~last;
   end
   // Memory takes whatever the bus holds while write is low.
   always @(posedge clk_sys)
   begin
      last <= data_in;
      if (!wr_n)
         mem[mem_addr] <= data_in;
      if (!rd_n && sel != 3'h0)
      begin
         io_got <= data_in;
         io_sel <= sel;
      end
   end
endmodule : ces_mem_model
`default_nettype wire

// ==== ces_pkg.sv ====
`default_nettype none
package ces_pkg;
   // ==========================================================
   // Machine states.
   typedef enum logic [2:0] {ST_RESET, ST_INIT, ST_FETCH, ST_EXEC, ST_EXEC2} ces_state_e;
   // ==========================================================
   // Arithmetic operations.
   typedef enum logic [1:0] {ALU_ADD, ALU_MMD, ALU_DMM, ALU_SHR} ces_alu_e;
endpackage : ces_pkg
`default_nettype wire

// ==== cpu_execute_sequencer_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module cpu_execute_sequencer_bench;
   // Program: load, add, branch, subtract, rotate, long branch,
   // skip, store, output, input, long skips, disable, idle.
   localparam logic [383:0] PROG = {128'h72FF74C4_33080000_77C43B0E_000076C3,
      128'h00200000_00000000_00000000_00000000, 128'h38005000_67A56C00_CEC60000_7100CC00};
   logic        clk_sys = 1'b0;
   logic        srst = 1'b1;
   logic        int_req = 1'b0;
   logic        dma_req = 1'b0;
   logic [3:0]  ext_flags = 4'h0;
   logic [15:0] mem_addr;
   logic [7:0]  data_in;
   logic [7:0]  data_out;
   logic        data_oe;
   logic        rd_n;
   logic        wr_n;
   logic [2:0]  io_sel;
   logic        io_ack;
   logic        carry;
   logic        ie;
   logic        q;
   int          err_total = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          t0;
   int          t1;
   // ===========================================================
   // Clock and cycle count.
   initial
   begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;
   ces_core uut(.clk_sys(clk_sys), .srst(srst), .clk_en(1'b1), .data_in(data_in),
      .external_flag_inputs(ext_flags), .int_req(int_req), .dma_req(dma_req),
      .mem_addr(mem_addr), .data_out(data_out), .data_oe(data_oe),
      .memory_read_strobe_n(rd_n), .memory_write_strobe_n(wr_n), .io_select_code(io_sel),
      .io_ack(io_ack), .carry_flag(carry), .interrupt_enable(ie), .q_flag(q));
   ces_mem_model u_mem(.clk_sys(clk_sys), .mem_addr(mem_addr), .data_out(data_out),
      .data_oe(data_oe), .rd_n(rd_n), .wr_n(wr_n), .sel(io_sel), .data_in(data_in));
   // ===========================================================
   // Shared helpers.
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask : chk
   // Waits for a read at the address; the time is the cycle count.
   task automatic wait_rd(input logic [15:0] a, output int t);
      for (int i = 0; i < 400; i++)
      begin
         @(posedge clk_sys);
         #1;
         if (mem_addr === a && rd_n === 1'b0)
            break;
      end
      chk("read address", a, mem_addr);
      t = cyc;
   endtask : wait_rd
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict
   // ===========================================================
   // Scenarios.
   task automatic t_reset();
      repeat (10) @(posedge clk_sys);
      #1;
      chk("reset bus", 16'h0000, 16'(data_out));
      chk("reset strobes", 16'h0003, 16'({rd_n, wr_n}));
      chk("reset enables", 16'h0006, 16'({ie, data_oe, q}));
      srst = 1'b0;
      wait_rd(16'h0000, t0);
   endtask : t_reset
   task automatic t_arith();
      wait_rd(16'h0008, t0);
      chk("carry after add", 16'h0001, 16'(carry));
      wait_rd(16'h000E, t0);
      chk("carry after subtract", 16'h0000, 16'(carry));
   endtask : t_arith
   task automatic t_branch();
      wait_rd(16'h000F, t0);
      wait_rd(16'h0020, t1);
      chk("carry after rotate", 16'h0001, 16'(carry));
      chk("long branch clocks", 16'h000C, 16'(t1 - t0));
      wait_rd(16'h0022, t0);
      chk("short skip clocks", 16'h0008, 16'(t0 - t1));
   endtask : t_branch
   task automatic t_io();
      wait_rd(16'h0024, t0);
      chk("stored byte", 16'h007F, 16'(u_mem.mem[16'h0023]));
      wait_rd(16'h0027, t0);
      chk("output byte", 16'h00A5, 16'(u_mem.io_got));
      chk("output select", 16'h0007, 16'(u_mem.io_sel));
      chk("input byte", 16'h00C4, 16'(u_mem.mem[16'h0027]));
   endtask : t_io
   task automatic t_idle();
      int seen;
      wait_rd(16'h002C, t0);
      chk("enable before disable", 16'h0001, 16'(ie));
      wait_rd(16'h002E, t0);
      chk("enable after disable", 16'h0000, 16'(ie));
      wait_rd(16'h0030, t0);
      int_req = 1'b1;
      seen = 0;
      repeat (40)
      begin
         @(posedge clk_sys);
         #1;
         seen += int'(io_ack === 1'b1);
      end
      chk("idle address", 16'h0030, mem_addr);
      chk("ack while disabled", 16'h0000, 16'(seen));
      dma_req = 1'b1;
      seen = 0;
      repeat (16)
      begin
         @(posedge clk_sys);
         #1;
         seen += int'(io_ack === 1'b1);
      end
      chk("ack for request", 16'h0001, 16'(seen > 0));
      chk("carry kept", 16'h0001, 16'(carry));
      dma_req = 1'b0;
   endtask : t_idle
   // ===========================================================
   // Main sequence.
   initial
   begin
      for (int i = 0; i < 65536; i++)
         u_mem.mem[i] = 8'h00;
      for (int i = 0; i < 48; i++)
         u_mem.mem[i] = PROG[383 - 8 * i -: 8];
      t_reset();
      t_arith();
      t_branch();
      t_io();
      t_idle();
      give_verdict();
   end
   // The program needs under 800 clocks; 4000 leaves wide margin.
   initial
   begin
      #20000;
      err_total++;
      give_verdict();
   end
endmodule : cpu_execute_sequencer_bench
`default_nettype wire
